// ===== hdl/protection_alarm_manager.sv
// Protection alarm manager: alarm indicator, alarm mask, output latching,
// foldback timer and overvoltage trip level with its limits.
// Assumes host commands arrive already parsed as one-cycle strobes with data.
`timescale 1ns/100ps
module protection_alarm_manager #(
  parameter int HOLD_CYCLES = prot_pkg::HOLD_CYCLES,
  parameter int TICK_CYCLES = prot_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [10:0] alarm_cond_i,
  input wire logic alarm_mask_wr_i,
  input wire logic [15:0] alarm_mask_data_i,
  input wire logic alarm_latch_wr_i,
  input wire logic [15:0] alarm_latch_data_i,
  input wire logic prot_clear_i,
  input wire logic adjust_hold_i,
  input wire logic out_on_req_i,
  input wire logic out_off_req_i,
  input wire logic constant_voltage_state_i,
  input wire logic constant_current_state_i,
  input wire logic fb_mode_wr_i,
  input wire logic [1:0] fb_mode_i,
  input wire logic fb_delay_wr_i,
  input wire logic [12:0] fb_delay_i,
  input wire logic analog_programming_mode_i,
  input wire logic [15:0] vset_i,
  input wire logic [15:0] vout_i,
  input wire logic ov_level_wr_i,
  input wire logic [15:0] ov_level_i,
  input wire logic ov_level_inc_i,
  input wire logic ov_level_dec_i,
  output logic alarm_led_o,
  output logic output_en_o,
  output logic [10:0] status_cond_o,
  output logic [10:0] alarm_mask_o,
  output logic [8:0] alarm_latch_o,
  output logic [1:0] fb_mode_o,
  output logic [12:0] fb_delay_o,
  output logic fb_locked_o,
  output logic [15:0] overvoltage_trip_level_o,
  output logic ov_warn_o,
  output logic err_push_o,
  output logic [15:0] err_code_o
);

  // ==========================================================================
  // Registers.
  logic [10:0] mask_r;
  logic [8:0] latch_r;
  logic [10:0] trip_r;
  logic [10:0] trip_nxt;
  logic led_r;
  logic out_state_r;
  logic out_state_nxt;
  logic [1:0] fb_mode_r;
  logic [12:0] fb_delay_r;
  logic sel_d_r;
  logic [15:0] ov_level_r;
  logic [15:0] ov_level_nxt;
  logic err_r;
  prot_pkg::fb_state_t fb_state_r;
  prot_pkg::fb_state_t fb_state_nxt;
  logic tick;
  logic hold_done;
  logic fb_done;

  // ==========================================================================
  // Timers: a 10 ms prescaler, the foldback delay and the knob hold time.
  interval_timer #(
    .WIDTH(32),
    .RELOAD(1'b1)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .load_i(1'b0),
    .load_val_i(TICK_CYCLES[31:0]),
    .run_i(1'b1),
    .tick_i(1'b1),
    .done_o(tick)
  );

  // Knob hold: reloaded while released, so only one unbroken press counts.
  interval_timer #(
    .WIDTH(32),
    .RELOAD(1'b0)
  ) u_hold (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .load_i(~adjust_hold_i),
    .load_val_i(HOLD_CYCLES[31:0]),
    .run_i(adjust_hold_i),
    .tick_i(1'b1),
    .done_o(hold_done)
  );

  // The first tick may come early by up to one tick period, a trade for
  // sharing one prescaler rather than a private one per delay.
  wire fb_load;
  // Value handed to the timer on a load, chosen in the commit path below.
  wire [12:0] fb_load_val;
  wire fb_run = (fb_state_r == prot_pkg::FB_TIMING);
  interval_timer #(
    .WIDTH(32),
    .RELOAD(1'b0)
  ) u_fold (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .load_i(fb_load),
    .load_val_i({19'h00000, fb_load_val}),
    .run_i(fb_run),
    .tick_i(tick),
    .done_o(fb_done)
  );

  // ==========================================================================
  // Mask and latch decode: only defined weights survive the write.
  wire [10:0] mask_nxt = alarm_mask_data_i[10:0] & prot_pkg::MASKABLE;
  wire [8:0] latch_nxt = alarm_latch_data_i[8:0] & prot_pkg::LATCHABLE;
  wire [10:0] en_mask = mask_r | ~prot_pkg::MASKABLE;
  wire [10:0] latch_eff = {2'h0, latch_r} | prot_pkg::ALWAYS_LATCH;

  // ==========================================================================
  // Overvoltage limits: floor at 105% of setpoint, ceiling at rated + 25%.
  // Operands are widened before each product, so no high bit of a setpoint
  // or a reading is lost to the width of the narrower factor.
  wire [20:0] vset_ext = {5'h00, vset_i};
  wire [20:0] vout_ext = {5'h00, vout_i};
  wire [20:0] vset_x21 = vset_ext * {16'h0000, prot_pkg::FLOOR_NUM};
  wire [20:0] floor_w = vset_x21 / {16'h0000, prot_pkg::PCT_DEN};
  wire [18:0] rated_x5 = {3'h0, prot_pkg::V_RATED} * {16'h0000, prot_pkg::CEIL_NUM};
  wire [20:0] ceil_w = {4'h0, rated_x5[18:2]};
  wire [20:0] lvl_ext = {5'h00, ov_level_r};
  wire [20:0] req_ext = {5'h00, ov_level_i};
  wire req_ok = (req_ext >= floor_w) && (req_ext <= ceil_w);
  wire can_dec = (lvl_ext > floor_w) && (ov_level_r != 16'h0000);
  wire can_inc = (lvl_ext < ceil_w) && (ov_level_r != 16'hFFFF);
  wire ov_over = (vout_i > ov_level_r);
  wire [20:0] vout_x20 = vout_ext * {16'h0000, prot_pkg::PCT_DEN};
  wire [20:0] lvl_x19 = lvl_ext * {16'h0000, prot_pkg::WARN_NUM};
  wire warn_nxt = analog_programming_mode_i && !ov_over && (vout_x20 >= lvl_x19);

  // Panel steps are one LSB; a request that would cross a limit is dropped.
  always_comb begin
    ov_level_nxt = ov_level_r;
    if (ov_level_wr_i && req_ok) begin
      ov_level_nxt = ov_level_i;
    end else if (ov_level_dec_i && can_dec) begin
      ov_level_nxt = ov_level_r - 16'h0001;
    end else if (ov_level_inc_i && can_inc) begin
      ov_level_nxt = ov_level_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Foldback delay validation: fine steps up to 5 s, coarse steps above.
  wire fine_ok = (fb_delay_i >= prot_pkg::DLY_MIN) && (fb_delay_i <= prot_pkg::DLY_FINE_MAX)
                 && ((fb_delay_i % prot_pkg::DLY_FINE_STEP) == 13'h0000);
  wire coarse_ok = (fb_delay_i >= prot_pkg::DLY_FINE_MAX) && (fb_delay_i <= prot_pkg::DLY_MAX)
                   && ((fb_delay_i % prot_pkg::DLY_COARSE_STEP) == 13'h0000);
  wire delay_commit = fb_delay_wr_i && (fine_ok || coarse_ok);
  wire mode_ok = (fb_mode_i == prot_pkg::FB_NONE) || (fb_mode_i == prot_pkg::FB_ON_VOLTAGE)
                 || (fb_mode_i == prot_pkg::FB_ON_CURRENT);

  // ==========================================================================
  // Foldback trigger tracking.
  wire fb_armed = (fb_mode_r != prot_pkg::FB_NONE);
  wire sel_state = (fb_mode_r == prot_pkg::FB_ON_VOLTAGE) ? constant_voltage_state_i :
                   (fb_mode_r == prot_pkg::FB_ON_CURRENT) ? constant_current_state_i : 1'b0;
  wire entry = sel_state & ~sel_d_r;
  wire commit_start = delay_commit & output_en_o & sel_state;
  // A commit that starts the timer must count the new delay, not the old.
  assign fb_load_val = delay_commit ? fb_delay_i : fb_delay_r;
  wire clear_evt = prot_clear_i | hold_done;
  assign fb_load = (fb_state_nxt == prot_pkg::FB_TIMING) &&
                   ((fb_state_r != prot_pkg::FB_TIMING) || commit_start);

  // Foldback controller; leaving the trigger state drops the count unfired.
  always_comb begin
    fb_state_nxt = fb_state_r;
    case (fb_state_r)
      prot_pkg::FB_IDLE: begin
        if (fb_armed && (entry || commit_start)) begin
          fb_state_nxt = prot_pkg::FB_TIMING;
        end
      end
      prot_pkg::FB_TIMING: begin
        if (!fb_armed || !sel_state) begin
          fb_state_nxt = prot_pkg::FB_IDLE;
        end else if (fb_done) begin
          fb_state_nxt = prot_pkg::FB_LOCKED;
        end
      end
      prot_pkg::FB_LOCKED: begin
        if (clear_evt) begin
          fb_state_nxt = prot_pkg::FB_IDLE;
        end
      end
      default: begin
        fb_state_nxt = prot_pkg::FB_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Alarm evaluation. Internal foldback and overvoltage detections join the
  // external conditions before masking, so a mask reaches foldback but not overvoltage.
  wire fb_locked = (fb_state_r == prot_pkg::FB_LOCKED);
  // The lock is its own cause and a clear ends it at the same edge, so it
  // must not count as a cause that survives the clear, or the alarm sticks.
  wire fb_lock_cause = fb_locked & ~clear_evt;
  wire [10:0] cond = alarm_cond_i | (fb_lock_cause ? prot_pkg::FOLD_BIT : 11'h000)
                     | (ov_over ? prot_pkg::OVER_BIT : 11'h000);
  wire [10:0] active = cond & en_mask;
  wire [10:0] cleared = trip_r & ~trip_nxt;
  wire latch_off = |(cleared & latch_eff);
  wire blocked = |(trip_nxt & ~prot_pkg::OUTPUT_SPARED);

  // Automatic alarms follow their condition; manual ones hold until a clear
  // arrives with the cause gone. A new event wins over a same-cycle clear.
  assign trip_nxt = active | (trip_r & ~prot_pkg::AUTO_CLEAR & ~{11{clear_evt}});

  // Output request: a latching alarm that clears forces the request off;
  // otherwise the pre-alarm request survives and returns with the clear.
  always_comb begin
    out_state_nxt = out_state_r;
    if (out_on_req_i) begin
      out_state_nxt = 1'b1;
    end
    if (latch_off || out_off_req_i) begin
      out_state_nxt = 1'b0;
    end
  end

  // Indicator: any trip lights it; once causes are gone it waits for a
  // clear or an output-on request, so a brief automatic alarm is not missed.
  wire led_nxt = (|trip_nxt) | (led_r & ~(clear_evt | out_on_req_i));

  // ==========================================================================
  // Configuration registers.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_r <= prot_pkg::MASK_RST;
      latch_r <= prot_pkg::LATCH_RST;
      fb_mode_r <= prot_pkg::FB_NONE;
      fb_delay_r <= prot_pkg::DLY_RST;
      ov_level_r <= prot_pkg::OV_LEVEL_RST;
    end else if (ce_i) begin
      if (alarm_mask_wr_i) begin
        mask_r <= mask_nxt;
      end
      if (alarm_latch_wr_i) begin
        latch_r <= latch_nxt;
      end
      if (fb_mode_wr_i && mode_ok) begin
        fb_mode_r <= fb_mode_i;
      end
      if (delay_commit) begin
        fb_delay_r <= fb_delay_i;
      end
      ov_level_r <= ov_level_nxt;
    end
  end

  // ==========================================================================
  // Alarm, output and foldback state.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trip_r <= 11'h000;
      led_r <= 1'b0;
      out_state_r <= 1'b0;
      output_en_o <= 1'b0;
      status_cond_o <= 11'h000;
      sel_d_r <= 1'b0;
      fb_state_r <= prot_pkg::FB_IDLE;
    end else if (ce_i) begin
      trip_r <= trip_nxt;
      led_r <= led_nxt;
      out_state_r <= out_state_nxt;
      output_en_o <= out_state_nxt & ~blocked;
      status_cond_o <= active;
      sel_d_r <= sel_state;
      fb_state_r <= fb_state_nxt;
    end
  end

  // ==========================================================================
  // Error reporting and warnings. The error pulse lasts one cycle.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_r <= 1'b0;
      err_code_o <= 16'h0000;
      ov_warn_o <= 1'b0;
    end else if (ce_i) begin
      err_r <= ov_level_wr_i & ~req_ok;
      if (ov_level_wr_i && !req_ok) begin
        err_code_o <= prot_pkg::ERR_SETTINGS_CONFLICT;
      end
      ov_warn_o <= warn_nxt;
    end
  end

  // ==========================================================================
  // Read-back of stored settings and state.
  assign err_push_o = err_r;
  assign alarm_led_o = led_r;
  assign alarm_mask_o = mask_r;
  assign alarm_latch_o = latch_r;
  assign fb_mode_o = fb_mode_r;
  assign fb_delay_o = fb_delay_r;
  assign fb_locked_o = fb_locked;
  assign overvoltage_trip_level_o = ov_level_r;

endmodule

// ===== hdl/prot_pkg.sv
// Constants shared by the protection alarm manager and its timers.
// Assumes a 100 MHz system clock; the cycle counts are derived from it here.
package prot_pkg;

  // ==========================================================================
  // Alarm bit positions, equal to the weight positions the host sums.
  localparam int N_ALARM = 11;
  localparam int A_AC_FAIL = 0;
  localparam int A_OVER_TEMP = 1;
  localparam int A_INTERLOCK = 2;
  localparam int A_FAN = 3;
  localparam int A_OVERVOLTAGE = 4;
  localparam int A_OVERCURRENT = 5;
  localparam int A_CHECKSUM = 6;
  localparam int A_INTERNAL = 7;
  localparam int A_FOLDBACK = 8;
  localparam int A_EXT_SHUTDOWN = 9;
  localparam int A_UNDERVOLTAGE = 10;

  // ==========================================================================
  // Mask and latch layouts.
  localparam logic [10:0] MASKABLE = 11'h70A;
  localparam logic [10:0] MASK_RST = 11'h70A;
  localparam logic [8:0] LATCHABLE = 9'h103;
  localparam logic [8:0] LATCH_RST = 9'h000;
  localparam logic [10:0] ALWAYS_LATCH = 11'h030;
  localparam logic [10:0] AUTO_CLEAR = 11'h20F;
  localparam logic [10:0] OUTPUT_SPARED = 11'h008;
  localparam logic [10:0] FOLD_BIT = 11'h100;
  localparam logic [10:0] OVER_BIT = 11'h010;

  // ==========================================================================
  // Foldback trigger selection and controller states.
  typedef enum logic [1:0] {
    FB_NONE = 2'h0,
    FB_ON_VOLTAGE = 2'h1,
    FB_ON_CURRENT = 2'h2
  } fb_mode_t;

  typedef enum logic [2:0] {
    FB_IDLE = 3'h1,
    FB_TIMING = 3'h2,
    FB_LOCKED = 3'h4
  } fb_state_t;

  // ==========================================================================
  // Timing. Foldback delay is held in ticks of 10 ms.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 10000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int HOLD_MS = 3000;
  localparam int HOLD_CYCLES = HOLD_MS * (1000000 / CLK_PERIOD_NS);
  localparam logic [12:0] DLY_MIN = 13'h0032;
  localparam logic [12:0] DLY_FINE_MAX = 13'h01F4;
  localparam logic [12:0] DLY_MAX = 13'h1388;
  localparam logic [12:0] DLY_FINE_STEP = 13'h0005;
  localparam logic [12:0] DLY_COARSE_STEP = 13'h0064;
  localparam logic [12:0] DLY_RST = 13'h0032;

  // ==========================================================================
  // Overvoltage limits as ratios, and the settings-conflict error code.
  localparam logic [4:0] FLOOR_NUM = 5'h15;
  localparam logic [4:0] PCT_DEN = 5'h14;
  localparam logic [4:0] WARN_NUM = 5'h13;
  localparam logic [2:0] CEIL_NUM = 3'h5;
  localparam int CEIL_SHIFT = 2;
  localparam logic [15:0] V_RATED = 16'h1000;
  localparam logic [15:0] OV_LEVEL_RST = 16'hFFFF;
  localparam logic [15:0] ERR_SETTINGS_CONFLICT = 16'hFF23;

endpackage

// ===== hdl/interval_timer.sv
// Down-counter that fires a one-cycle pulse when a loaded interval runs out.
// Assumes the caller supplies a tick enable; with RELOAD it free-runs.
`timescale 1ns/100ps
module interval_timer #(
  parameter int WIDTH = 32,
  parameter bit RELOAD = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_val_i,
  input wire logic run_i,
  input wire logic tick_i,
  output logic done_o
);

  // ==========================================================================
  // Count selection.
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  wire step = run_i & tick_i;
  wire is_zero = (count_r == {WIDTH{1'b0}});
  wire is_last = (count_r == {{(WIDTH-1){1'b0}}, 1'b1});

  // A one-shot timer parks at zero so it fires exactly once per load.
  assign count_nxt = load_i ? load_val_i :
                     !step ? count_r :
                     (RELOAD && (is_last || is_zero)) ? load_val_i :
                     is_zero ? count_r : count_r - 1'b1;

  // ==========================================================================
  // State.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= {WIDTH{1'b0}};
      done_o <= 1'b0;
    end else if (ce_i) begin
      count_r <= count_nxt;
      done_o <= step & is_last & ~load_i;
    end
  end

endmodule

// ===== test/panel_knob_model.sv
// Front-panel knob model: holds the adjust control pressed for a set count.
// Assumes one press request at a time; a new press restarts the count.
`timescale 1ns/100ps
module panel_knob_model (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic press_i,
  input wire logic [7:0] len_i,
  output logic hold_o
);
  logic [7:0] left_r;

  // ==========
  // Press counter; the knob lets go on its own so a short hold is possible.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_r <= 8'h00;
    end else if (press_i) begin
      left_r <= len_i;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end
  assign hold_o = left_r != 8'h00;
endmodule

// ===== test/prot_props.sv
// Checker for the protection alarm manager, bound to its top module.
// Assumes one clock domain and a setpoint that holds still during writes.
`timescale 1ns/100ps
module prot_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ov_level_wr_i,
  input wire logic [15:0] vset_i,
  input wire logic analog_programming_mode_i,
  input wire logic prot_clear_i,
  input wire logic out_on_req_i,
  input wire logic adjust_hold_i,
  input wire logic constant_voltage_state_i,
  input wire logic constant_current_state_i,
  input wire logic alarm_led_o,
  input wire logic output_en_o,
  input wire logic [10:0] status_cond_o,
  input wire logic [10:0] alarm_mask_o,
  input wire logic fb_locked_o,
  input wire logic [15:0] overvoltage_trip_level_o,
  input wire logic ov_warn_o,
  input wire logic err_push_o,
  input wire logic [15:0] err_code_o
);
  // ==========
  // Sampling setup.
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_lock_rise;
    $rose(fb_locked_o);
  endsequence

  // ==========
  // Properties.
  a_err_code: assert property (err_push_o |-> err_code_o == 16'hFF23)
    else $error("error code is not settings conflict");
  a_err_cause: assert property ($rose(err_push_o) |->
    $past(ov_level_wr_i) || $past(ov_level_wr_i, 2))
    else $error("error pushed without a level write");
  a_level_span: assert property ($changed(overvoltage_trip_level_o) |->
    overvoltage_trip_level_o <= 16'h1400 &&
    32'(overvoltage_trip_level_o) >= (32'($past(vset_i)) * 21) / 20)
    else $error("trip level outside its span");
  a_trip_out_off: assert property ((status_cond_o & 11'h7F7) != 11'h000 |-> !output_en_o)
    else $error("output on during a non-fan alarm");
  a_status_masked: assert property (
    (status_cond_o & 11'h70A & ~alarm_mask_o & ~$past(alarm_mask_o)) == 11'h000)
    else $error("masked alarm shows in status");
  a_led_on_alarm: assert property (status_cond_o != 11'h000 |-> alarm_led_o)
    else $error("alarm without indicator");
  a_led_hold: assert property ($fell(alarm_led_o) |->
    $past(prot_clear_i || out_on_req_i || adjust_hold_i, 1) ||
    $past(prot_clear_i || out_on_req_i, 2))
    else $error("indicator went dark without a clear");
  a_fb_lock_cause: assert property (s_lock_rise |->
    $past(constant_voltage_state_i || constant_current_state_i))
    else $error("foldback locked outside regulation");
  a_lock_out_off: assert property (fb_locked_o |-> ##[0:2] !output_en_o)
    else $error("output stays on while foldback locked");
  a_warn_mode: assert property (ov_warn_o |-> $past(analog_programming_mode_i))
    else $error("warning outside analog mode");
endmodule

bind protection_alarm_manager prot_props chk_u (.sys_clk_i, .rst_n_i, .ov_level_wr_i, .vset_i,
  .analog_programming_mode_i, .prot_clear_i, .out_on_req_i, .adjust_hold_i,
  .constant_voltage_state_i, .constant_current_state_i, .alarm_led_o, .output_en_o,
  .status_cond_o, .alarm_mask_o, .fb_locked_o, .overvoltage_trip_level_o, .ov_warn_o,
  .err_push_o, .err_code_o);

// ===== test/tb_top.sv
// Self-checking bench for the protection alarm manager.
// Assumes hold and tick counts shortened to 40 and 4 cycles.
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, cv = 1'b0, cc = 1'b0, ana = 1'b0, press = 1'b0;
  logic [10:0] cond = 11'h000;
  logic [9:0] stb = 10'h000;
  logic [15:0] d = 16'h0000, vset = 16'h1000, vout = 16'h0000;
  logic [7:0] len = 8'h00;
  logic hold, led, oe, lock, warn, epush;
  logic [10:0] st, mk;
  logic [8:0] lt;
  logic [1:0] fm;
  logic [12:0] fd;
  logic [15:0] lvl, ec;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  localparam logic [25:0] DLY [9] = '{{13'h0031, 13'h0032}, {13'h01F4, 13'h01F4},
    {13'h01F5, 13'h01F4}, {13'h0258, 13'h0258}, {13'h026C, 13'h0258}, {13'h1388, 13'h1388},
    {13'h1389, 13'h1388}, {13'h0037, 13'h0037}, {13'h0032, 13'h0032}};

  // ==========
  // Clock, and a cycle ceiling far above the 1700 or so cycles needed.
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  protection_alarm_manager #(.HOLD_CYCLES(40), .TICK_CYCLES(4)) dut_u (
    .sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .alarm_cond_i(cond),
    .alarm_mask_wr_i(stb[0]), .alarm_mask_data_i(d), .alarm_latch_wr_i(stb[1]),
    .alarm_latch_data_i(d), .prot_clear_i(stb[2]), .adjust_hold_i(hold),
    .out_on_req_i(stb[3]), .out_off_req_i(stb[4]), .constant_voltage_state_i(cv),
    .constant_current_state_i(cc), .fb_mode_wr_i(stb[5]), .fb_mode_i(d[1:0]),
    .fb_delay_wr_i(stb[6]), .fb_delay_i(d[12:0]), .analog_programming_mode_i(ana),
    .vset_i(vset), .vout_i(vout), .ov_level_wr_i(stb[7]), .ov_level_i(d),
    .ov_level_inc_i(stb[8]), .ov_level_dec_i(stb[9]), .alarm_led_o(led),
    .output_en_o(oe), .status_cond_o(st), .alarm_mask_o(mk), .alarm_latch_o(lt),
    .fb_mode_o(fm), .fb_delay_o(fd), .fb_locked_o(lock), .overvoltage_trip_level_o(lvl),
    .ov_warn_o(warn), .err_push_o(epush), .err_code_o(ec));
  panel_knob_model knob_u (.sys_clk_i(clk), .rst_n_i(rst_n), .press_i(press), .len_i(len),
    .hold_o(hold));

  // ==========
  // Access tasks: strobe k carries d for one cycle; waits end just past an edge.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input int k, input logic [15:0] v);
    @(posedge clk);
    stb[k] <= 1'b1;
    d <= v;
    @(posedge clk);
    stb <= 10'h000;
    #1;
  endtask
  task automatic setc(input logic [10:0] v);
    @(posedge clk);
    cond <= v;
    tk(1);
  endtask
  task automatic setv(input logic [15:0] v);
    @(posedge clk);
    vout <= v;
    tk(1);
  endtask
  task automatic knob(input logic [7:0] n);
    @(posedge clk);
    press <= 1'b1;
    len <= n;
    @(posedge clk);
    press <= 1'b0;
    tk(60);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tk(1);
    chk(16'(mk), 16'h070A);
    chk(lvl, 16'hFFFF);
    // Host weight sums for mask and latch; stray weights must drop out.
    cmd(0, 16'h0502);
    chk(16'(mk), 16'h0502);
    cmd(0, 16'hFFFF);
    chk(16'(mk), 16'h070A);
    cmd(1, 16'hFFFF);
    chk(16'(lt), 16'h0103);
    cmd(1, 16'h0102);
    chk(16'(lt), 16'h0102);
    // Delay commits at both step ranges and just off them; mode 3 is ignored.
    for (int i = 0; i < 9; i++) begin
      cmd(6, {3'h0, DLY[i][25:13]});
      chk(16'(fd), 16'(DLY[i][12:0]));
    end
    cmd(5, 16'h0001);
    cmd(5, 16'h0003);
    chk(16'(fm), 16'h0001);
    // Trip level: floor is 4300 for a setpoint of 4096, ceiling 5120.
    cmd(7, 16'h10CB);
    chk(16'(epush), 16'h0001);
    chk(ec, 16'hFF23);
    chk(lvl, 16'hFFFF);
    cmd(7, 16'h10CC);
    cmd(9, 16'h0000);
    chk(lvl, 16'h10CC);
    cmd(7, 16'h1401);
    cmd(7, 16'h1400);
    cmd(9, 16'h0000);
    chk(lvl, 16'h13FF);
    cmd(8, 16'h0000);
    cmd(8, 16'h0000);
    chk(lvl, 16'h1400);
    // Warning band in analog mode, then an overvoltage trip that stays latched.
    cmd(3, 16'h0000);
    @(posedge clk);
    ana <= 1'b1;
    setv(16'h1300);
    chk(16'(warn), 16'h0001);
    setv(16'h12FF);
    chk(16'(warn), 16'h0000);
    setv(16'h1401);
    chk(16'(oe), 16'h0000);
    chk(16'(st), 16'h0010);
    setv(16'h1000);
    cmd(2, 16'h0000);
    tk(1);
    chk(16'(oe), 16'h0000);
    // Automatic alarm restores output unless latched; indicator needs on or clear.
    cmd(3, 16'h0000);
    setc(11'h001);
    chk(16'(oe), 16'h0000);
    setc(11'h000);
    chk(16'(oe), 16'h0001);
    chk(16'(led), 16'h0001);
    cmd(3, 16'h0000);
    chk(16'(led), 16'h0000);
    cmd(1, 16'h0103);
    setc(11'h001);
    setc(11'h000);
    chk(16'(oe), 16'h0000);
    cmd(2, 16'h0000);
    cmd(0, 16'h0702);
    setc(11'h008);
    chk(16'(st), 16'h0000);
    chk(16'(led), 16'h0000);
    setc(11'h000);
    cmd(0, 16'h070A);
    // Every alarm source lights the indicator; only the fan spares the output.
    for (int i = 0; i < 11; i++) begin
      cmd(3, 16'h0000);
      setc(11'(1 << i));
      chk(16'(led), 16'h0001);
      chk(16'(oe), 16'(i == 3));
      setc(11'h000);
      cmd(2, 16'h0000);
      tk(1);
      chk(16'(led), 16'h0000);
    end
    cmd(4, 16'h0000);
    chk(16'(oe), 16'h0000);
    // Foldback: a short stay is cancelled, a full delay locks, knob must be held.
    cmd(3, 16'h0000);
    @(posedge clk);
    cv <= 1'b1;
    tk(150);
    @(posedge clk);
    cv <= 1'b0;
    tk(300);
    chk(16'(lock), 16'h0000);
    @(posedge clk);
    cv <= 1'b1;
    tk(220);
    chk(16'(lock), 16'h0001);
    chk(16'(oe), 16'h0000);
    knob(8'd20);
    chk(16'(lock), 16'h0001);
    knob(8'd45);
    chk(16'(lock), 16'h0000);
    // Committing the delay while already regulating starts the timer at once.
    cmd(3, 16'h0000);
    cmd(6, 16'h0032);
    tk(220);
    chk(16'(lock), 16'h0001);
    cmd(2, 16'h0000);
    tk(1);
    chk(16'(lock), 16'h0000);
    // No trigger selected, then current regulation as the trigger.
    cmd(5, 16'h0000);
    @(posedge clk);
    cv <= 1'b0;
    tk(2);
    @(posedge clk);
    cv <= 1'b1;
    tk(220);
    chk(16'(lock), 16'h0000);
    cmd(5, 16'h0002);
    @(posedge clk);
    cv <= 1'b0;
    cc <= 1'b1;
    tk(220);
    chk(16'(lock), 16'h0001);
    tally_and_finish();
  end
endmodule
